// ===== lbs_top.sv
// Purpose: lamp clock and burst dimming source/receiver with gate drives
// Assumes: mode inputs static during operation, level code from same clock
// Notes:   lamp receiver clock arrives as its own clock domain
//
// Function
// - lamp receiver uses external sync clock
// - lamp source drives internal clock out
// - burst receiver uses external burst waveform
// - burst source drives internal waveform out
// - external burst oscillator clock sets timing
// - valid received pulse yields minimum burst
// - burst duty floors at minimum, then follows
// - held low burst input disables gates
// - each gate high at most 44 percent
// - gates alternate per half, never both
// - level input sets burst duty
`default_nettype none

module lbs_top #(
   parameter int LAMP_DIV  = lbs_pkg::LAMP_DIV_DEF,
   parameter int BURST_DIV = lbs_pkg::BURST_DIV_DEF
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        lamp_rx_mode,
   input  wire logic                        burst_rx_mode,
   input  wire logic                        burst_osc_ext,
   input  wire logic                        lamp_sync_clk,
   output var  logic                        lamp_sync_pin_o,
   output var  logic                        lamp_sync_pin_oe,
   input  wire logic                        burst_sync_pin_i,
   output var  logic                        burst_sync_pin_o,
   output var  logic                        burst_sync_pin_oe,
   input  wire logic                        burst_osc_pin,
   input  wire logic [lbs_pkg::LEVEL_W-1:0] analog_level_input,
   output var  logic                        gate_drive_a,
   output var  logic                        gate_drive_b
);

   localparam int LW = lbs_pkg::LAMP_W;
   localparam int BW = lbs_pkg::BURST_W;
   localparam int VW = lbs_pkg::LEVEL_W;

   // ----------------------------------------------------------------
   // link domain: lamp clock from peers
   // ----------------------------------------------------------------
   // reset reaches the link domain as a level through two flops
   logic link_rst_meta_r;
   logic link_rst_r;
   logic link_tog_r;
   logic link_tog_nxt;

   always_comb
   begin
      link_tog_nxt = ~link_tog_r;
   end

   always_ff @(posedge lamp_sync_clk)
   begin
      link_rst_meta_r <= rst;
      link_rst_r      <= link_rst_meta_r;
      if (link_rst_r)
      begin
         link_tog_r <= 1'b0;
      end
      else
      begin
         link_tog_r <= link_tog_nxt;
      end
   end

   // ----------------------------------------------------------------
   // crossings into the system clock
   // ----------------------------------------------------------------
   logic [2:0] sync_q;

   lbs_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({link_tog_r, burst_sync_pin_i, burst_osc_pin}),
      .q   (sync_q)
   );

   logic tog_s;
   logic rx_burst_s;
   logic osc_s;
   assign tog_s      = sync_q[2];
   assign rx_burst_s = sync_q[1];
   assign osc_s      = sync_q[0];

   logic tog_d_r;
   logic rx_burst_d_r;
   logic osc_d_r;
   logic edges_nxt_tog;
   logic lamp_edge;
   logic rx_rise;
   logic osc_rise;

   always_comb
   begin
      edges_nxt_tog = tog_s;
      lamp_edge     = tog_s ^ tog_d_r;
      rx_rise       = rx_burst_s & ~rx_burst_d_r;
      osc_rise      = osc_s & ~osc_d_r;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tog_d_r      <= 1'b0;
         rx_burst_d_r <= 1'b0;
         osc_d_r      <= 1'b0;
      end
      else
      begin
         tog_d_r      <= edges_nxt_tog;
         rx_burst_d_r <= rx_burst_s;
         osc_d_r      <= osc_s;
      end
   end

   // ----------------------------------------------------------------
   // lamp period counter
   // ----------------------------------------------------------------
   logic [LW-1:0] lamp_cnt_r;
   logic [LW-1:0] lamp_cnt_nxt;
   logic [LW-1:0] lamp_per_r;
   logic [LW-1:0] lamp_per_nxt;
   logic          lamp_wrap;

   always_comb
   begin
      lamp_wrap    = 1'b0;
      lamp_per_nxt = lamp_per_r;
      lamp_cnt_nxt = lamp_cnt_r;
      if (lamp_rx_mode)
      begin
         // period measured between received edges
         if (lamp_edge)
         begin
            lamp_wrap    = 1'b1;
            lamp_per_nxt = lamp_cnt_r + 16'h0001;
            lamp_cnt_nxt = lbs_pkg::LAMP_CNT_RST;
         end
         else if (lamp_cnt_r != {LW{1'b1}})
         begin
            // saturates so a stopped peer clock leaves gates off
            lamp_cnt_nxt = lamp_cnt_r + 16'h0001;
         end
      end
      else
      begin
         lamp_per_nxt = LW'(LAMP_DIV);
         if (lamp_cnt_r >= LW'(LAMP_DIV - 1))
         begin
            lamp_wrap    = 1'b1;
            lamp_cnt_nxt = lbs_pkg::LAMP_CNT_RST;
         end
         else
         begin
            lamp_cnt_nxt = lamp_cnt_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lamp_cnt_r <= lbs_pkg::LAMP_CNT_RST;
         lamp_per_r <= LW'(LAMP_DIV);
      end
      else
      begin
         lamp_cnt_r <= lamp_cnt_nxt;
         lamp_per_r <= lamp_per_nxt;
      end
   end

   // ----------------------------------------------------------------
   // burst period and duty
   // ----------------------------------------------------------------
   logic [BW-1:0] bcnt_r;
   logic [BW-1:0] bcnt_nxt;
   logic [BW-1:0] bper_r;
   logic [BW-1:0] bper_nxt;
   logic [VW-1:0] level_eff;
   logic [BW+VW-1:0] duty_lhs;
   logic [BW+VW-1:0] duty_rhs;
   logic          src_wave;

   always_comb
   begin
      bper_nxt = bper_r;
      bcnt_nxt = bcnt_r;
      if (burst_osc_ext)
      begin
         // external oscillator edges define the period
         if (osc_rise)
         begin
            bper_nxt = bcnt_r + 24'h000001;
            bcnt_nxt = lbs_pkg::BURST_CNT_RST;
         end
         else if (bcnt_r != {BW{1'b1}})
         begin
            bcnt_nxt = bcnt_r + 24'h000001;
         end
      end
      else
      begin
         bper_nxt = BW'(BURST_DIV);
         if (bcnt_r >= BW'(BURST_DIV - 1))
         begin
            bcnt_nxt = lbs_pkg::BURST_CNT_RST;
         end
         else
         begin
            bcnt_nxt = bcnt_r + 24'h000001;
         end
      end
      // a grounded level still gives the minimum burst
      level_eff = (analog_level_input < lbs_pkg::BURST_MIN_LEVEL) ?
                  lbs_pkg::BURST_MIN_LEVEL : analog_level_input;
      duty_lhs  = {bcnt_r, {VW{1'b0}}};
      duty_rhs  = (BW+VW)'(bper_r) * (BW+VW)'(level_eff);
      src_wave  = duty_lhs < duty_rhs;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bcnt_r <= lbs_pkg::BURST_CNT_RST;
         bper_r <= BW'(BURST_DIV);
      end
      else
      begin
         bcnt_r <= bcnt_nxt;
         bper_r <= bper_nxt;
      end
   end

   // ----------------------------------------------------------------
   // burst receiver with minimum-duty stretch
   // ----------------------------------------------------------------
   logic [BW-1:0] rx_cnt_r;
   logic [BW-1:0] rx_cnt_nxt;
   logic [BW-1:0] rx_per_r;
   logic [BW-1:0] rx_per_nxt;
   logic [BW-1:0] rx_min_on;
   logic [BW+VW-1:0] rx_min_prod;
   logic          rx_wave;

   always_comb
   begin
      rx_per_nxt = rx_per_r;
      rx_cnt_nxt = rx_cnt_r;
      if (rx_rise)
      begin
         rx_per_nxt = rx_cnt_r + 24'h000001;
         rx_cnt_nxt = lbs_pkg::BURST_CNT_RST;
      end
      else if (rx_cnt_r != {BW{1'b1}})
      begin
         rx_cnt_nxt = rx_cnt_r + 24'h000001;
      end
      // minimum on-time: min duty of received period, never below one valid pulse
      rx_min_prod = (BW+VW)'(rx_per_r) * (BW+VW)'(lbs_pkg::BURST_MIN_LEVEL);
      rx_min_on   = rx_min_prod[BW+VW-1:VW];
      if (rx_min_on < BW'(lbs_pkg::RX_MIN_PULSE_CYC))
      begin
         rx_min_on = BW'(lbs_pkg::RX_MIN_PULSE_CYC);
      end
      // high input tracks; a short one is stretched; held low ends it
      rx_wave = rx_burst_s | (rx_cnt_r < rx_min_on);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // saturated so nothing is stretched before a first edge
         rx_cnt_r <= {BW{1'b1}};
         rx_per_r <= BW'(BURST_DIV);
      end
      else
      begin
         rx_cnt_r <= rx_cnt_nxt;
         rx_per_r <= rx_per_nxt;
      end
   end

   // ----------------------------------------------------------------
   // gate drives and pins
   // ----------------------------------------------------------------
   logic [LW-1:0]         half;
   logic [LW+6:0]         on_prod;
   logic [LW-1:0]         on_len;
   logic                  burst_on;
   lbs_pkg::lbs_gate_s    gate_r;
   lbs_pkg::lbs_gate_s    gate_nxt;
   lbs_pkg::lbs_pin_s     lpin_r;
   lbs_pkg::lbs_pin_s     lpin_nxt;
   lbs_pkg::lbs_pin_s     bpin_r;
   lbs_pkg::lbs_pin_s     bpin_nxt;

   always_comb
   begin
      half     = {1'b0, lamp_per_r[LW-1:1]};
      on_prod  = (LW+7)'(lamp_per_r) * (LW+7)'(lbs_pkg::LAMP_MAX_DUTY_PCT);
      on_len   = LW'(on_prod / (LW+7)'(lbs_pkg::PCT_FULL));
      burst_on = burst_rx_mode ? rx_wave : src_wave;
      // on_len below half keeps the two phases apart
      gate_nxt.a = burst_on & (lamp_cnt_r < on_len);
      gate_nxt.b = burst_on & (lamp_cnt_r >= half)
                   & ((lamp_cnt_r - half) < on_len);
      if (lamp_wrap)
      begin
         // a fresh period always begins with both off
         gate_nxt.a = 1'b0;
         gate_nxt.b = 1'b0;
      end
      lpin_nxt.oe = ~lamp_rx_mode;
      lpin_nxt.o  = ~lamp_rx_mode & (lamp_cnt_r < half);
      bpin_nxt.oe = ~burst_rx_mode;
      bpin_nxt.o  = ~burst_rx_mode & src_wave;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gate_r <= '0;
         lpin_r <= '0;
         bpin_r <= '0;
      end
      else
      begin
         gate_r <= gate_nxt;
         lpin_r <= lpin_nxt;
         bpin_r <= bpin_nxt;
      end
   end

   assign gate_drive_a      = gate_r.a;
   assign gate_drive_b      = gate_r.b;
   assign lamp_sync_pin_o   = lpin_r.o;
   assign lamp_sync_pin_oe  = lpin_r.oe;
   assign burst_sync_pin_o  = bpin_r.o;
   assign burst_sync_pin_oe = bpin_r.oe;

endmodule // lbs_top

`default_nettype wire

// ===== lbs_pkg.sv
// Purpose: shared constants and carriers for the lamp and burst timing block
// Assumes: 100 MHz system clock
// Notes:   all counts derived from printed times and the clock rate
`default_nettype none

package lbs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int RX_MIN_PULSE_US  = 25;
   // least time, whole cycles
   localparam int RX_MIN_PULSE_CYC = RX_MIN_PULSE_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int LAMP_W  = 16;
   localparam int BURST_W = 24;
   localparam int LEVEL_W = 7;

   // ----------------------------------------------------------------
   // duty figures
   // ----------------------------------------------------------------
   localparam int LAMP_MAX_DUTY_PCT = 44;
   localparam int PCT_FULL          = 100;
   localparam logic [LEVEL_W-1:0] BURST_MIN_LEVEL = 7'h03;

   // ----------------------------------------------------------------
   // default oscillator divisions (system clock cycles)
   // ----------------------------------------------------------------
   localparam int LAMP_DIV_DEF  = 2000;     // 50 kHz lamp rate
   localparam int BURST_DIV_DEF = 1000000;  // 100 Hz burst rate

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [LAMP_W-1:0]  LAMP_CNT_RST  = 16'h0000;
   localparam logic [BURST_W-1:0] BURST_CNT_RST = 24'h000000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic a;
      logic b;
   } lbs_gate_s;

   typedef struct packed {
      logic o;
      logic oe;
   } lbs_pin_s;

endpackage

`default_nettype wire

// ===== lbs_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels from another domain or a pin
// Notes:   first stage is read only by the second
`default_nettype none

module lbs_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end

endmodule // lbs_sync2

`default_nettype wire

// ===== lbs_props_props.sv
// Purpose: port checker for lbs_top
// Assumes: modes change only under reset
// Notes:   rx on-time bound allows one cycle of link jitter
`default_nettype none
module lbs_props #(
   parameter int LAMP_DIV  = 40,
   parameter int BURST_DIV = 4000
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       lamp_rx_mode,
   input wire logic       burst_rx_mode,
   input wire logic       burst_osc_ext,
   input wire logic       lamp_sync_clk,
   input wire logic       lamp_sync_pin_o,
   input wire logic       lamp_sync_pin_oe,
   input wire logic       burst_sync_pin_i,
   input wire logic       burst_sync_pin_o,
   input wire logic       burst_sync_pin_oe,
   input wire logic       burst_osc_pin,
   input wire logic [6:0] analog_level_input,
   input wire logic       gate_drive_a,
   input wire logic       gate_drive_b
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PCT     = lbs_pkg::LAMP_MAX_DUTY_PCT;
   localparam int ON_SRC  = LAMP_DIV * PCT / lbs_pkg::PCT_FULL;
   localparam int ON_RX   = 17 * PCT / lbs_pkg::PCT_FULL;
   localparam int LOW_OFF = lbs_pkg::RX_MIN_PULSE_CYC + 10;
   logic [11:0] run_a_r, run_b_r, low_r, osc_r, lim;
   logic [11:0] run_a_nxt, run_b_nxt, low_nxt, osc_nxt;
   logic        osc_d_r;
   // low and osc counts saturate so a stuck line never wraps; the gate run counts do not
   always_comb
   begin
      run_a_nxt = gate_drive_a ? run_a_r + 12'h001 : 12'h000;
      run_b_nxt = gate_drive_b ? run_b_r + 12'h001 : 12'h000;
      low_nxt   = burst_sync_pin_i ? 12'h000 : low_r + {11'h000, ~&low_r};
      osc_nxt   = (burst_osc_pin && !osc_d_r) ? 12'h000 : osc_r + {11'h000, ~&osc_r};
      lim       = lamp_rx_mode ? 12'(ON_RX) : 12'(ON_SRC);
   end
   always_ff @(posedge clk)
   begin
      {run_a_r, run_b_r, low_r, osc_r, osc_d_r} <= rst ? 49'h0 :
         {run_a_nxt, run_b_nxt, low_nxt, osc_nxt, burst_osc_pin};
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_excl;
      !(gate_drive_a && gate_drive_b);
   endproperty
   a_excl: assert property (p_excl)
      else $error("both gates high");
   property p_lamp_dir;
      !$past(rst) |-> lamp_sync_pin_oe == !lamp_rx_mode && !(lamp_rx_mode && lamp_sync_pin_o);
   endproperty
   a_lamp_dir: assert property (p_lamp_dir)
      else $error("lamp pin direction wrong");
   property p_burst_dir;
      !$past(rst) |-> burst_sync_pin_oe == !burst_rx_mode && !(burst_rx_mode && burst_sync_pin_o);
   endproperty
   a_burst_dir: assert property (p_burst_dir)
      else $error("burst pin direction wrong");
   property p_gate_max;
      (!gate_drive_a || run_a_r < lim) && (!gate_drive_b || run_b_r < lim);
   endproperty
   a_gate_max: assert property (p_gate_max)
      else $error("gate on too long");
   property p_a_half;
      gate_drive_a && !lamp_rx_mode |-> lamp_sync_pin_o || $past(lamp_sync_pin_o);
   endproperty
   a_a_half: assert property (p_a_half)
      else $error("gate a outside first half");
   property p_src_gate;
      !burst_rx_mode && !burst_sync_pin_o && !$past(burst_sync_pin_o) && !$past(burst_sync_pin_o, 2)
         |-> !gate_drive_a && !gate_drive_b;
   endproperty
   a_src_gate: assert property (p_src_gate)
      else $error("gates on outside burst");
   property p_rx_burst;
      burst_rx_mode && $rose(burst_sync_pin_i) |-> ##[1:60] (gate_drive_a || gate_drive_b);
   endproperty
   a_rx_burst: assert property (p_rx_burst)
      else $error("no burst after pulse");
   property p_rx_off;
      burst_rx_mode && low_r > LOW_OFF |-> !gate_drive_a && !gate_drive_b;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("gates on with input low");
   property p_osc;
      burst_osc_ext && !burst_rx_mode && $rose(burst_sync_pin_o) |-> osc_r <= 12'h008;
   endproperty
   a_osc: assert property (p_osc)
      else $error("burst start not tied to osc edge");
   c_gate_b: cover property ($rose(gate_drive_b));
   c_rx: cover property (burst_rx_mode && $rose(burst_sync_pin_i));
   c_osc: cover property (burst_osc_ext && $rose(burst_sync_pin_o));
   c_floor: cover property (!burst_rx_mode && analog_level_input < 7'h03
      && $rose(burst_sync_pin_o));
   c_link: cover property (@(posedge lamp_sync_clk) lamp_rx_mode && !lamp_sync_pin_oe);
endmodule // lbs_props
bind lbs_top lbs_props #(.LAMP_DIV(LAMP_DIV), .BURST_DIV(BURST_DIV)) u_props (
   .clk(clk), .rst(rst), .lamp_rx_mode(lamp_rx_mode), .burst_rx_mode(burst_rx_mode),
   .burst_osc_ext(burst_osc_ext), .lamp_sync_clk(lamp_sync_clk),
   .lamp_sync_pin_o(lamp_sync_pin_o), .lamp_sync_pin_oe(lamp_sync_pin_oe),
   .burst_sync_pin_i(burst_sync_pin_i), .burst_sync_pin_o(burst_sync_pin_o),
   .burst_sync_pin_oe(burst_sync_pin_oe), .burst_osc_pin(burst_osc_pin),
   .analog_level_input(analog_level_input), .gate_drive_a(gate_drive_a),
   .gate_drive_b(gate_drive_b));
`default_nettype wire

// ===== lbs_peer.sv
// Purpose: cascaded peer driving lamp clock and burst line
// Assumes: peer lamp clock runs free at 160 ns, 50 percent
// Notes:   burst line only reaches the block while it receives
`default_nettype none
module lbs_peer (
   output var logic lamp_clk,
   output var logic burst_wave
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      lamp_clk = 1'b0;
      #37;
      forever #80 lamp_clk = ~lamp_clk;
   end
   initial burst_wave = 1'b0;
   task automatic burst(input int hi_ns, input int lo_ns);
      burst_wave = 1'b1;
      #hi_ns;
      burst_wave = 1'b0;
      #lo_ns;
   endtask
endmodule // lbs_peer
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for lbs_top
// Assumes: small dividers, peer on both sync lines
// Notes:   rx burst length judged from gate activity
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LD  = 40;
   localparam int BD  = 4000;
   localparam int PCT = lbs_pkg::LAMP_MAX_DUTY_PCT;
   logic       clk, rst, lamp_rx, burst_rx, osc_ext, osc_pin;
   logic [6:0] level;
   logic       peer_lamp, peer_burst, lamp_o, lamp_oe, burst_o, burst_oe, ga, gb;
   wire        lamp_line  = lamp_oe ? lamp_o : peer_lamp;
   wire        burst_line = burst_oe ? burst_o : peer_burst;
   int         mismatches, checks, lamp_hi, burst_hi, max_a, first, last, rise_at, burst_per;
   lbs_top #(.LAMP_DIV(LD), .BURST_DIV(BD)) dut_u (
      .clk(clk), .rst(rst), .lamp_rx_mode(lamp_rx), .burst_rx_mode(burst_rx),
      .burst_osc_ext(osc_ext), .lamp_sync_clk(lamp_line), .lamp_sync_pin_o(lamp_o),
      .lamp_sync_pin_oe(lamp_oe), .burst_sync_pin_i(burst_line), .burst_sync_pin_o(burst_o),
      .burst_sync_pin_oe(burst_oe), .burst_osc_pin(osc_pin), .analog_level_input(level),
      .gate_drive_a(ga), .gate_drive_b(gb));
   lbs_peer peer_u (.lamp_clk(peer_lamp), .burst_wave(peer_burst));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // external burst oscillator, period 3000 cycles
   initial
   begin
      osc_pin = 1'b0;
      forever
      begin
         repeat (1500) @(posedge clk);
         #1 osc_pin = ~osc_pin;
      end
   end
   task automatic end_sim();
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // four-state arguments so an unknown output never slips through
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // twenty cycles cover a link edge; a late link reset settles in the idle span
   task automatic do_reset(input logic lr, input logic br, input logic oe, input int lv);
      rst = 1'b1;
      lamp_rx = lr;
      burst_rx = br;
      osc_ext = oe;
      level = lv[6:0];
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      repeat (100) @(posedge clk);
      #1;
      chk(lamp_oe, !lr);
      chk(burst_oe, !br);
   endtask
   task automatic meas(input int n);
      int ra;
      logic pb;
      {lamp_hi, burst_hi, max_a, burst_per, ra} = 160'h0;
      first = -1;
      last = -1;
      rise_at = -1;
      pb = burst_o;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         #1;
         ra = (ga === 1'b1) ? ra + 1 : 0;
         max_a = (ra > max_a) ? ra : max_a;
         lamp_hi += (lamp_o === 1'b1);
         burst_hi += (burst_o === 1'b1);
         if (ga === 1'b1 || gb === 1'b1)
         begin
            last = i;
            first = (first < 0) ? i : first;
         end
         if (burst_o === 1'b1 && pb === 1'b0)
         begin
            burst_per = (rise_at >= 0) ? i - rise_at : 0;
            rise_at = i;
         end
         pb = burst_o;
      end
   endtask
   task automatic t_src_levels();
      int lv[4] = '{0, 3, 64, 127};
      int m;
      foreach (lv[k])
      begin
         do_reset(1'b0, 1'b0, 1'b0, lv[k]);
         m = (lv[k] < lbs_pkg::BURST_MIN_LEVEL) ? lbs_pkg::BURST_MIN_LEVEL : lv[k];
         meas(BD);
         chk(burst_hi, (BD * m + 127) / 128);
         chk(lamp_hi, BD / 2);
         chk(max_a, LD * PCT / 100);
      end
   endtask
   task automatic t_osc();
      do_reset(1'b0, 1'b0, 1'b1, 64);
      meas(6000);
      meas(6000);
      chk(burst_per, 3000);
      chk(burst_hi, 3000);
   endtask
   task automatic t_rx();
      do_reset(1'b1, 1'b1, 1'b0, 64);
      fork
         peer_u.burst(3000, 60000);
         meas(6000);
      join
      chk(last - first >= 2460 && last - first <= 2520, 1);
      chk(max_a, 16 * PCT / 100);
      fork
         peer_u.burst(35000, 60000);
         meas(6000);
      join
      chk(last - first >= 3460 && last - first <= 3520, 1);
      meas(3000);
      chk(first, -1);
   endtask
   initial
   begin
      mismatches = 0;
      checks = 0;
      rst = 1'b1;
      lamp_rx = 1'b0;
      burst_rx = 1'b0;
      osc_ext = 1'b0;
      level = 7'h00;
      t_src_levels();
      t_osc();
      t_rx();
      end_sim();
   end
   initial
   begin
      #1000000;
      mismatches++;
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
